// File: design/ephemeral_key_state_tracker.sv
// Ephemeral key register and metadata tracker with XOR cipher port.
// Assumes the command decoder reports each finished command through
// the command register and stages key words beforehand.
//
// Contract
// - Sleep or power loss invalidates ephemeral key.
// - Key holds 256 bits from seed or digest.
// - Key contents never readable by host.
// - Four-bit slot index records digest source.
// - Origin flag zero random, one host-only.
// - Digest-from-slot flag; index ignored when zero.
// - Verify-only set when restricted key used.
// - Valid flag gates any use of key.
// - Resets and sleep clear valid; idle retains.
// - Other commands clear valid after execution.
// - CRC-rejected command leaves valid unchanged.
// - Verify keeps valid only on successful copy.
// - Error in seed or digest clears valid.
// - Seed and digest overwrite each other.
// - XOR with digest encrypts and decrypts.
// - Slot select uses low four key-id bits.
// - Full 16-bit key id goes into hash.
// - Stored keys hashed as 256-bit values.
// - Seed combines host challenge with random.
// - Random seeds unique; host-only ones not.
// - Challenge responses are 256-bit digests.
// - Key feeds crypto commands and data protection.
`timescale 1ns/1ps
module ephemeral_key_state_tracker import ekey_pkg::*; (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdata,
	input wire logic [KEY_W-1:0] digestIn,
	input wire logic [KEY_W-1:0] randomIn,
	input wire logic randomValid,
	input wire logic brownOut,
	input wire logic watchdogExpired,
	input wire logic tamperDetected,
	input wire logic [WIDX_W-1:0] keyWordSel,
	output logic [DATA_W-1:0] keyWord,
	output logic keyUsable,
	output key_meta_t metaOut,
	output logic [KEY_SLOT_INDEX_W-1:0] hashKeyId,
	output logic [SLOT_W-1:0] slotSelect,
	output logic seedUnique
);
	bus_req_t req;
	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	////////////////////////////////////////////////////////////////////
	// State
	key_meta_t meta_reg, meta_next;
	logic sleep_reg, sleep_next;
	logic idle_reg, idle_next;
	logic [KEY_SLOT_INDEX_W-1:0] key_slot_index_reg, key_slot_index_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [DATA_W-1:0] stage_reg [WORDS];
	logic [DATA_W-1:0] stage_next [WORDS];
	logic [DATA_W-1:0] xorRes_reg, xorRes_next;
	logic uniq_reg, uniq_next;
	logic load_reg, load_next;
	logic [WIDX_W-1:0] loadIdx_reg, loadIdx_next;
	logic [KEY_W-1:0] loadVal_reg, loadVal_next;
	logic usable_reg, usable_next;
	logic [SLOT_W-1:0] slotSel_reg, slotSel_next;
	logic [KEY_SLOT_INDEX_W-1:0] hashId_reg, hashId_next;

	logic memWe;
	logic [WIDX_W-1:0] memWaddr;
	logic [DATA_W-1:0] memWdata;
	logic [WIDX_W-1:0] memRaddr;
	logic [DATA_W-1:0] memRdata;

	logic cmdWr;
	cmd_op_t op;
	logic killEvt;

	assign cmdWr = req.wr && req.addr == REG_CMD;
	assign op = cmd_op_t'(req.wdata[CMD_OP_LSB +: CMD_OP_W]);
	// Sleep or any reset-class event kills the key validity
	assign killEvt = sleep_reg || brownOut || watchdogExpired ||
		tamperDetected;

	////////////////////////////////////////////////////////////////////
	// Key storage; 256 bits as eight words
	key_word_mem u_mem (
		.mclk(mclk),
		.we(memWe),
		.waddr(memWaddr),
		.wdata(memWdata),
		.raddr(memRaddr),
		.rdata(memRdata)
	);

	assign memWe = load_reg;
	assign memWaddr = loadIdx_reg;
	assign memWdata = loadVal_reg[loadIdx_reg*DATA_W +: DATA_W];
	// Internal consumers read this port; the XOR engine uses digestIn, not the key
	assign memRaddr = keyWordSel;

	////////////////////////////////////////////////////////////////////
	// Metadata and command tracking
	always_comb begin
		meta_next = meta_reg;
		uniq_next = uniq_reg;
		load_next = load_reg;
		loadIdx_next = loadIdx_reg;
		loadVal_next = loadVal_reg;
		if (load_reg) begin
			if (loadIdx_reg == WIDX_W'(WORDS - 1)) begin
				load_next = 1'b0;
			end else begin
				loadIdx_next = loadIdx_reg + 1'b1;
			end
		end
		if (cmdWr && !req.wdata[CMD_CRC]) begin
			case (op)
				OP_SEED: begin
					if (req.wdata[CMD_ERR]) begin
						meta_next.valid = 1'b0;
					end else begin
						meta_next = META_RESET;
						meta_next.valid = 1'b1;
						// Host-only seed carries no uniqueness promise
						meta_next.randomOrigin =
							!(req.wdata[CMD_RAND] && randomValid);
						uniq_next = !meta_next.randomOrigin;
						loadVal_next = meta_next.randomOrigin ?
							digestIn : (digestIn ^ randomIn);
						load_next = 1'b1;
						loadIdx_next = '0;
					end
				end
				OP_DIGEST: begin
					if (req.wdata[CMD_ERR]) begin
						meta_next.valid = 1'b0;
					end else begin
						meta_next.valid = 1'b1;
						meta_next.digestFromSlot =
							req.wdata[CMD_SLOT];
						meta_next.slotIndex = req.wdata[CMD_SLOT] ?
							slotOf(key_slot_index_reg) : '0;
						meta_next.verifyOnly =
							req.wdata[CMD_VONLY];
						loadVal_next = digestIn;
						load_next = 1'b1;
						loadIdx_next = '0;
					end
				end
				OP_MACVERIFY: begin
					// Successful copy is the one way valid survives
					if (!(req.wdata[CMD_COPY] && !req.wdata[CMD_ERR])) begin
						meta_next.valid = 1'b0;
					end
				end
				default: begin
					meta_next.valid = 1'b0;
				end
			endcase
		end
		if (killEvt) begin
			meta_next = META_RESET;
			load_next = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register port
	always_comb begin
		sleep_next = sleep_reg;
		idle_next = idle_reg;
		key_slot_index_next = key_slot_index_reg;
		stage_next = stage_reg;
		rdata_next = UNMAPPED_VAL;
		if (req.wr) begin
			if (req.addr == REG_CTRL) begin
				sleep_next = req.wdata[CTRL_SLEEP];
				// Idle keeps contents; nothing is cleared here
				idle_next = req.wdata[CTRL_IDLE];
			end else if (req.addr == REG_KEY_SLOT_INDEX) begin
				key_slot_index_next = req.wdata[KEY_SLOT_INDEX_W-1:0];
			end else if (req.addr >= REG_DATA_BASE &&
				req.addr < REG_XOR_BASE) begin
				stage_next[req.addr[WIDX_W+1:2]] = req.wdata;
			end
		end
		if (req.rd) begin
			if (req.addr == REG_CTRL) begin
				rdata_next = {{(DATA_W-2){1'b0}}, idle_reg, sleep_reg};
			end else if (req.addr == REG_STATUS) begin
				rdata_next = {{(DATA_W-$bits(key_meta_t)-1){1'b0}},
					uniq_reg, meta_reg};
			end else if (req.addr == REG_KEY_SLOT_INDEX) begin
				rdata_next = {{(DATA_W-KEY_SLOT_INDEX_W){1'b0}}, key_slot_index_reg};
			end else if (req.addr == REG_SLOTSEL) begin
				rdata_next = {{(DATA_W-SLOT_W){1'b0}},
					slotOf(key_slot_index_reg)};
			end else if (req.addr >= REG_XOR_BASE &&
				req.addr < REG_XOR_BASE + 8'h20) begin
				// Only the ciphered word leaves; the key never does
				rdata_next = xorRes_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// XOR cipher and consumer outputs
	always_comb begin
		// Same operation both ways: plain^d = cipher, cipher^d = plain
		xorRes_next = stage_reg[keyWordSel] ^
			digestIn[keyWordSel*DATA_W +: DATA_W];
		// Track next state so usable never outlives valid by a cycle
		usable_next = meta_next.valid && !load_next;
		slotSel_next = slotOf(key_slot_index_reg);
		hashId_next = key_slot_index_reg;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= META_RESET;
			sleep_reg <= 1'b0;
			idle_reg <= 1'b0;
			key_slot_index_reg <= '0;
			rdata_reg <= '0;
			xorRes_reg <= '0;
			uniq_reg <= 1'b0;
			load_reg <= 1'b0;
			loadIdx_reg <= '0;
			loadVal_reg <= '0;
			usable_reg <= 1'b0;
			slotSel_reg <= '0;
			hashId_reg <= '0;
			for (int i = 0; i < WORDS; i++) begin
				stage_reg[i] <= '0;
			end
		end else begin
			meta_reg <= meta_next;
			sleep_reg <= sleep_next;
			idle_reg <= idle_next;
			key_slot_index_reg <= key_slot_index_next;
			rdata_reg <= rdata_next;
			xorRes_reg <= xorRes_next;
			uniq_reg <= uniq_next;
			load_reg <= load_next;
			loadIdx_reg <= loadIdx_next;
			loadVal_reg <= loadVal_next;
			usable_reg <= usable_next;
			slotSel_reg <= slotSel_next;
			hashId_reg <= hashId_next;
			stage_reg <= stage_next;
		end
	end

	assign regRdata = rdata_reg;
	assign keyWord = memRdata;
	assign keyUsable = usable_reg;
	assign metaOut = meta_reg;
	assign hashKeyId = hashId_reg;
	assign slotSelect = slotSel_reg;
	assign seedUnique = uniq_reg;
endmodule : ephemeral_key_state_tracker

// File: design/ekey_pkg.sv
// Package for the ephemeral key state tracker.
// Assumes a single 50 MHz clock domain and a simple register port.
package ekey_pkg;
	localparam int KEY_W = 256;
	localparam int SLOT_W = 4;
	localparam int KEY_SLOT_INDEX_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int WORDS = KEY_W / DATA_W;
	localparam int WIDX_W = 3;
	localparam int CLK_NS = 20;

	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_KEY_SLOT_INDEX = 8'h08;
	localparam logic [7:0] REG_SLOTSEL = 8'h0c;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_DATA_BASE = 8'h40;
	localparam logic [7:0] REG_XOR_BASE = 8'h60;
	localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;

	// Control bit positions
	localparam int CTRL_SLEEP = 0;
	localparam int CTRL_IDLE = 1;
	localparam int CTRL_MODE = 2;

	// Command field positions in REG_CMD write
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 3;
	localparam int CMD_ERR = 4;
	localparam int CMD_CRC = 5;
	localparam int CMD_RAND = 6;
	localparam int CMD_SLOT = 7;
	localparam int CMD_VONLY = 8;
	localparam int CMD_COPY = 9;

	typedef enum logic [2:0] {
		OP_SEED = 3'h0,
		OP_DIGEST = 3'h1,
		OP_MACVERIFY = 3'h2,
		OP_OTHER = 3'h3
	} cmd_op_t;

	typedef struct packed {
		logic valid;
		logic verifyOnly;
		logic digestFromSlot;
		logic randomOrigin;
		logic [SLOT_W-1:0] slotIndex;
	} key_meta_t;

	localparam key_meta_t META_RESET = '0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	function automatic logic [SLOT_W-1:0] slotOf(
		input logic [KEY_SLOT_INDEX_W-1:0] key_slot_index
	);
		return key_slot_index[SLOT_W-1:0];
	endfunction : slotOf
endpackage : ekey_pkg

// File: design/key_word_mem.sv
// Small memory holding the 256-bit ephemeral key as 32-bit words.
// Assumes writes and reads share mclk; read data is registered.
`timescale 1ns/1ps
module key_word_mem import ekey_pkg::*; #(
	parameter int DEPTH = WORDS,
	parameter int W = DATA_W
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [WIDX_W-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [WIDX_W-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : key_word_mem

// File: tb/ekey_engine_model.sv
// Digest engine and random source beside the key tracker.
// Assumes words are fixed so the bench can predict them.
`timescale 1ns/1ps
module ekey_engine_model import ekey_pkg::*; (
	output logic [KEY_W-1:0] digestIn,
	output logic [KEY_W-1:0] randomIn,
	output logic randomValid
);
	assign randomValid = 1'b1;
	for (genvar i = 0; i < WORDS; i++) begin : g_w
		assign digestIn[i*DATA_W +: DATA_W] = 32'h01010101 * (i + 1);
		assign randomIn[i*DATA_W +: DATA_W] = 32'hf00d0000 + i;
	end
endmodule : ekey_engine_model

// File: tb/ekey_assertions.sv
// Port checks for the ephemeral key tracker.
// Assumes the random source is always ready.
`timescale 1ns/1ps
module ekey_assertions import ekey_pkg::*; (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [DATA_W-1:0] regRdata,
	input wire logic brownOut,
	input wire logic watchdogExpired,
	input wire logic tamperDetected,
	input wire logic keyUsable,
	input wire key_meta_t metaOut,
	input wire logic [KEY_SLOT_INDEX_W-1:0] hashKeyId,
	input wire logic [SLOT_W-1:0] slotSelect
);
	logic sleepReg, sleepNext, kill, cmdOk, err;
	logic [2:0] op;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	always_comb begin
		sleepNext = sleepReg;
		if (regWr && regAddr == REG_CTRL) sleepNext = regWdata[CTRL_SLEEP];
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) sleepReg <= 1'b0;
		else sleepReg <= sleepNext;
	end
	// Sleep on either side of the write edge excluded from command checks
	assign kill = brownOut | watchdogExpired | tamperDetected | sleepReg
		| sleepNext;
	assign cmdOk = regWr && regAddr == REG_CMD && !regWdata[CMD_CRC] && !kill;
	assign op = regWdata[2:0];
	assign err = regWdata[CMD_ERR];
	////////////////////////////////////////////////////////////////////////
	slot_low_bits_a: assert property (slotSelect == hashKeyId[3:0])
		else $error("slot select differs from key id");
	kill_clears_a: assert property ((brownOut | watchdogExpired |
		tamperDetected) |=> !metaOut.valid && !keyUsable)
		else $error("kill event left key valid");
	read_idle_a: assert property (!regRd |=> regRdata == 32'h0)
		else $error("read data outside read slot");
	crc_keeps_a: assert property (regWr && regAddr == REG_CMD &&
		regWdata[CMD_CRC] && !kill |=> $stable(metaOut))
		else $error("crc reject changed metadata");
	other_clears_a: assert property (cmdOk && op >= 3'h3 |=>
		!metaOut.valid) else $error("other command kept valid");
	error_clears_a: assert property (cmdOk && op < 3'h2 && err |=>
		!metaOut.valid) else $error("failed load kept valid");
	usable_valid_a: assert property (keyUsable |-> metaOut.valid)
		else $error("usable while invalid");
	seed_flags_a: assert property (cmdOk && op == 3'h0 && !err |=>
		metaOut.valid && !metaOut.digestFromSlot &&
		metaOut.randomOrigin != $past(regWdata[CMD_RAND]))
		else $error("seed flags wrong");
	digest_flags_a: assert property (cmdOk && op == 3'h1 && !err |=>
		metaOut.valid && metaOut.verifyOnly == $past(regWdata[CMD_VONLY]) &&
		metaOut.digestFromSlot == $past(regWdata[CMD_SLOT]))
		else $error("digest flags wrong");
	copy_keeps_a: assert property (cmdOk && op == 3'h2 &&
		regWdata[CMD_COPY] && !err |=> $stable(metaOut.valid))
		else $error("copy changed valid");
endmodule : ekey_assertions
bind ephemeral_key_state_tracker ekey_assertions chk_i (.mclk(mclk),
	.rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .brownOut(brownOut),
	.watchdogExpired(watchdogExpired), .tamperDetected(tamperDetected),
	.keyUsable(keyUsable), .metaOut(metaOut), .hashKeyId(hashKeyId),
	.slotSelect(slotSelect));

// File: tb/ephemeral_key_state_tracker_tb.sv
// Bench for the ephemeral key tracker: register calls and checks.
// Assumes the engine model supplies fixed digest and random words.
`timescale 1ns/1ps
module ephemeral_key_state_tracker_tb import ekey_pkg::*;;
	logic mclk = 0, rstn = 0, regWr = 0, regRd = 0, keyUsable, seedUnique;
	logic brownOut = 0, watchdogExpired = 0, tamperDetected = 0;
	logic randomValid;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0, regRdata, keyWord;
	logic [KEY_W-1:0] digestIn, randomIn;
	logic [WIDX_W-1:0] keyWordSel = '0;
	logic [KEY_SLOT_INDEX_W-1:0] hashKeyId;
	logic [SLOT_W-1:0] slotSelect;
	key_meta_t metaOut;
	int n_fail = 0, cmp_count = 0;
	always #(CLK_NS / 2) mclk = ~mclk;
	ekey_engine_model eng (.digestIn(digestIn), .randomIn(randomIn),
		.randomValid(randomValid));
	ephemeral_key_state_tracker dut (.mclk(mclk), .rstn(rstn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .digestIn(digestIn), .randomIn(randomIn),
		.randomValid(randomValid), .brownOut(brownOut),
		.watchdogExpired(watchdogExpired), .tamperDetected(tamperDetected),
		.keyWordSel(keyWordSel), .keyWord(keyWord), .keyUsable(keyUsable),
		.metaOut(metaOut), .hashKeyId(hashKeyId), .slotSelect(slotSelect),
		.seedUnique(seedUnique));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		chk("regRdata", e, regRdata);
	endtask : rd
	// Fixed wait covers the eight-cycle key load
	task automatic cmd(input logic [31:0] d);
		wr(REG_CMD, d);
		repeat (10) @(posedge mclk);
		#1;
	endtask : cmd
	task automatic flags(input logic [3:0] e);
		chk("metaFlags", {28'h0, e}, {28'h0, metaOut[7:4]});
	endtask : flags
	task automatic end_sim;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	initial begin
		#(CLK_NS * 4000);
		n_fail++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		#1;
		flags(4'h0);
		chk("keyUsable", 0, keyUsable);
		rd(8'hf0, 32'h0);
		wr(REG_KEY_SLOT_INDEX, 32'habc5);
		rd(REG_SLOTSEL, 32'h5);
		chk("hashKeyId", 32'habc5, hashKeyId);
		chk("slotSelect", 32'h5, slotSelect);
		for (int i = 0; i < WORDS; i++) begin
			wr(REG_DATA_BASE + 8'(4 * i), 32'h5a5a0000 + i);
		end
		cmd(32'h40);
		flags(4'h8);
		chk("seedUnique", 1, seedUnique);
		chk("keyUsable", 1, keyUsable);
		rd(REG_STATUS, 32'h180);
		rd(REG_DATA_BASE, 32'h0);
		for (int i = 0; i < WORDS; i++) begin
			@(posedge mclk);
			keyWordSel <= WIDX_W'(i);
			@(posedge mclk);
			#1;
			chk("keyWord", 32'h01010101 * (i + 1) ^ (32'hf00d0000 + i),
				keyWord);
			rd(REG_XOR_BASE, 32'h5a5a0000 + i ^ 32'h01010101 * (i + 1));
		end
		cmd(32'h0);
		flags(4'h9);
		chk("seedUnique", 0, seedUnique);
		cmd(32'h181);
		flags(4'hf);
		chk("slotIndex", 5, metaOut.slotIndex);
		cmd(32'h23);
		flags(4'hf);
		cmd(32'h202);
		flags(4'hf);
		cmd(32'h3);
		chk("valid", 0, metaOut.valid);
		cmd(32'h40);
		cmd(32'h11);
		chk("valid", 0, metaOut.valid);
		cmd(32'h40);
		wr(REG_CTRL, 32'h2);
		#1;
		chk("valid", 1, metaOut.valid);
		for (int k = 0; k < 4; k++) begin
			cmd(32'h40);
			@(posedge mclk);
			brownOut <= (k == 0);
			watchdogExpired <= (k == 1);
			tamperDetected <= (k == 2);
			if (k == 3) wr(REG_CTRL, 32'h1);
			@(posedge mclk);
			{brownOut, watchdogExpired, tamperDetected} <= 3'h0;
			if (k == 3) wr(REG_CTRL, 32'h0);
			#1;
			chk("valid", 0, metaOut.valid);
			chk("keyUsable", 0, keyUsable);
		end
		cmd(32'h40);
		rstn <= 1'b0;
		#(CLK_NS * 2);
		rstn <= 1'b1;
		flags(4'h0);
		end_sim();
	end
endmodule : ephemeral_key_state_tracker_tb
